// File: common/sdmac_pkg.sv
// Constants and types shared by the SDRAM command and address block
package sdmac_pkg;

    // Port width codes on the port width field
    localparam logic [1:0] PW_32 = 2'h0;
    localparam logic [1:0] PW_8  = 2'h1;
    localparam logic [1:0] PW_16 = 2'h2;

    // Logical address shift per port width
    localparam logic [1:0] SH_8  = 2'h0;
    localparam logic [1:0] SH_16 = 2'h1;
    localparam logic [1:0] SH_32 = 2'h2;

    // Widths
    localparam int LA_W    = 28;
    localparam int PA_W    = 14;
    localparam int UP_W    = 6;
    localparam int WAIT_W  = 4;
    localparam int OPTB_W  = 8;
    localparam int BLEN_W  = 9;
    localparam int LAT_W   = 3;

    // Row, column and upper field positions in the shifted logical address
    localparam int ROW_HI_MSB = 21;
    localparam int ROW_HI_LSB = 19;
    localparam int ROW_AP     = 18;
    localparam int ROW_LO_MSB = 17;
    localparam int ROW_LO_LSB = 8;
    localparam int COL_MSB    = 7;
    localparam int UP_LSB     = 22;

    // Mode register op-code image
    localparam logic       OP_WB_SINGLE = 1'h1;
    localparam logic [1:0] OP_MODE_STD  = 2'h0;
    localparam logic       OP_BT_SEQ    = 1'h0;
    localparam logic [2:0] OP_BL_FULL   = 3'h7;

    // Burst lengths per burst length field code
    localparam logic [8:0] BL_2    = 9'h002;
    localparam logic [8:0] BL_4    = 9'h004;
    localparam logic [8:0] BL_8    = 9'h008;
    localparam logic [8:0] BL_PAGE = 9'h100;

    // Strobe pin codes {row, column, write enable}, low active
    localparam logic [2:0] PC_NOP   = 3'h7;
    localparam logic [2:0] PC_ACT   = 3'h3;
    localparam logic [2:0] PC_RW_RD = 3'h5;
    localparam logic [2:0] PC_RW_WR = 3'h4;
    localparam logic [2:0] PC_BTERM = 3'h6;
    localparam logic [2:0] PC_PRE   = 3'h2;
    localparam logic [2:0] PC_REF   = 3'h1;
    localparam logic [2:0] PC_LOAD  = 3'h0;

    // Address phases
    localparam logic [1:0] PH_ROW  = 2'h0;
    localparam logic [1:0] PH_COL  = 2'h1;
    localparam logic [1:0] PH_MODE = 2'h2;

    // Requested commands
    typedef enum logic [2:0] {
        SDMAC_NOP   = 3'h0,
        SDMAC_ACT   = 3'h1,
        SDMAC_READ  = 3'h2,
        SDMAC_WRITE = 3'h3,
        SDMAC_BTERM = 3'h4,
        SDMAC_PRE   = 3'h5,
        SDMAC_REF   = 3'h6
    } sdmac_cmd_t;

    // Sequencer states, one-hot
    typedef enum logic [1:0] {
        ST_READY = 2'b01,
        ST_WAIT  = 2'b10
    } sdmac_state_t;

    // Shift of the logical address for a port width
    function automatic logic [1:0] sdmac_shift(input logic [1:0] pw);
        logic [1:0] s;
        s = SH_32;
        if (pw == PW_8) begin
            s = SH_8;
        end else if (pw == PW_16) begin
            s = SH_16;
        end
        return s;
    endfunction

endpackage

// File: src/sdmac_addr_mux.sv
// Row, column and mode image multiplexer onto the SDRAM address pins
`timescale 1ns/1ns
`default_nettype none
module sdmac_addr_mux
    import sdmac_pkg::*;
(
    // Configuration
    input  wire logic [1:0]      portWidthField,
    input  wire logic [1:0]      burstTimingField,
    // Address source
    input  wire logic [1:0]      phase,
    input  wire logic [LA_W-1:0] logicalAddr,
    // Pin images
    output logic      [PA_W-1:0] pinAddr,
    output logic                 pinAp,
    output logic      [UP_W-1:0] upperAddr
);
    logic [LA_W-1:0] shifted;
    logic [9:0]      opCode;

    // Logical address aligned to the port width
    assign shifted = logicalAddr >> sdmac_shift(portWidthField);
    // Spare upper bits for extra row or bank use
    assign upperAddr = shifted[UP_LSB +: UP_W];
    // Mode register op-code with latency field plus one
    assign opCode = {OP_WB_SINGLE, OP_MODE_STD, {1'b0, burstTimingField} + 3'h1, OP_BT_SEQ, OP_BL_FULL};

    // Phase selection
    always_comb begin
        pinAddr = '0;
        pinAp   = 1'b0;
        if (phase == PH_ROW) begin
            pinAddr[13:11] = shifted[ROW_HI_MSB:ROW_HI_LSB];
            pinAddr[10]    = shifted[ROW_AP];
            pinAddr[9:0]   = shifted[ROW_LO_MSB:ROW_LO_LSB];
            pinAp          = shifted[ROW_AP];
        end else if (phase == PH_COL) begin
            pinAddr[7:0] = shifted[COL_MSB:0];
        end else begin
            pinAddr[9:0] = opCode;
        end
    end
endmodule
`default_nettype wire

// File: src/sdmac_wait_timer.sv
// Down counter that times wait states after row commands
`timescale 1ns/1ns
`default_nettype none
module sdmac_wait_timer
    import sdmac_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic              clkEn,
    // Control
    input  wire logic              start,
    input  wire logic [WAIT_W-1:0] loadValue,
    // Status
    output logic                   lastCycle
);
    logic [WAIT_W-1:0] count;
    logic [WAIT_W-1:0] next_count;

    // Count down to zero
    always_comb begin
        next_count = count;
        if (start) begin
            next_count = loadValue;
        end else if (count != '0) begin
            next_count = count - WAIT_W'(1);
        end
    end

    // Count register
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            count <= '0;
        end else if (clkEn) begin
            count <= next_count;
        end
    end

    assign lastCycle = (count == WAIT_W'(1));
endmodule
`default_nettype wire

// File: src/sdmac_cmd_ctrl.sv
// SDRAM command encoder and Mode-1 address sequencer
// Function
// - Wait states follow precharge and active commands.
// - New burst timing applies without new load-mode.
// - New burst length applies to later transfers.
// - Option B field used only with external acknowledge.
// - Row and column phases share address pins.
// - 8-bit port row, column, mode mapping.
// - 16-bit port row, column, mode mapping.
// - 32-bit port row, column, mode mapping.
// - Upper three pins zero in column phase.
// - Spare upper logical bits for rows or banks.
// - Commands presented with chip select low.
// - Strobe pins carry row, column, write, A10/AP.
// - Inhibit has select high; NOP strobes high.
// - Active encoding with row A10 on AP.
// - Read encoding with AP low.
// - Write encoding with AP low.
// - Burst terminate encoding.
// - Precharge encoding with AP high.
// - Refresh encoding.
// - Load-mode encoding with op-code on address.
// - Load-mode issued when valid bit is set.
// - Op-code: single writes, sequential, full page.
`timescale 1ns/1ns
`default_nettype none
module sdmac_cmd_ctrl
    import sdmac_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic              clkEn,
    // Chip select configuration
    input  wire logic              sdramMode,
    input  wire logic              validBit,
    input  wire logic [1:0]        portWidthField,
    input  wire logic [1:0]        burstTimingField,
    input  wire logic [1:0]        burstLengthField,
    input  wire logic [WAIT_W-1:0] waitField,
    input  wire logic              externalTransferAckEnable,
    input  wire logic [OPTB_W-1:0] optionBField,
    // Command request
    input  wire logic              cmdValid,
    input  wire sdmac_cmd_t        cmdCode,
    input  wire logic [LA_W-1:0]   cmdAddr,
    // Request status
    output logic                   cmdReady,
    output logic                   loadModeDone,
    output logic                   readDataStrobe,
    output logic      [BLEN_W-1:0] burstCycles,
    output logic      [OPTB_W-1:0] effectiveOptionB,
    // SDRAM pins
    output logic                   chipSelect_n,
    output logic                   columnStrobe3Pin_n,
    output logic                   columnStrobe2Pin_n,
    output logic                   columnStrobe1Pin_n,
    output logic                   columnStrobe0Pin_n,
    output logic      [PA_W-1:0]   sdramAddr,
    output logic      [UP_W-1:0]   upperAddr
);
    sdmac_state_t    state;
    sdmac_state_t    next_state;
    logic            validPrev;
    logic            loadPend;
    logic            next_loadPend;
    logic            next_cmdReady;
    logic            next_loadModeDone;
    logic            next_readDataStrobe;
    logic [BLEN_W-1:0] next_burstCycles;
    logic [OPTB_W-1:0] next_effectiveOptionB;
    logic            next_chipSelect_n;
    logic [2:0]      strobes;
    logic [2:0]      next_strobes;
    logic            apPin;
    logic            next_apPin;
    logic [PA_W-1:0] next_sdramAddr;
    logic [UP_W-1:0] next_upperAddr;
    logic [LAT_W-1:0] latCount;
    logic [LAT_W-1:0] next_latCount;
    logic            accept;
    logic            timerStart;
    logic            timerLast;
    logic [1:0]      phase;
    logic [PA_W-1:0] muxAddr;
    logic            muxAp;
    logic [UP_W-1:0] muxUpper;
    logic            loadNow;

    // Request handshake and load-mode slot
    assign accept  = cmdValid && cmdReady && (state == ST_READY);
    assign loadNow = loadPend && !accept && (state == ST_READY);

    // Address phase from the command in progress
    always_comb begin
        phase = PH_COL;
        if (loadNow) begin
            phase = PH_MODE;
        end else if (cmdCode == SDMAC_ACT) begin
            phase = PH_ROW;
        end
    end

    sdmac_addr_mux u_addr_mux (
        .portWidthField   (portWidthField),
        .burstTimingField (burstTimingField),
        .phase            (phase),
        .logicalAddr      (cmdAddr),
        .pinAddr          (muxAddr),
        .pinAp            (muxAp),
        .upperAddr        (muxUpper)
    );

    // Wait states only after row commands with a nonzero field
    assign timerStart = accept && (waitField != '0)
                        && (cmdCode == SDMAC_ACT || cmdCode == SDMAC_PRE);

    sdmac_wait_timer u_wait_timer (
        .clk       (clk),
        .arst_n    (arst_n),
        .clkEn     (clkEn),
        .start     (timerStart),
        .loadValue (waitField),
        .lastCycle (timerLast)
    );

    // Sequencer and pin encoding
    always_comb begin
        next_state        = state;
        next_chipSelect_n = 1'b1;
        next_strobes      = PC_NOP;
        next_apPin        = 1'b1;
        next_sdramAddr    = sdramAddr;
        next_upperAddr    = upperAddr;
        next_loadModeDone = 1'b0;
        next_burstCycles  = burstCycles;
        next_loadPend     = (loadPend && !loadNow) || (validBit && !validPrev && sdramMode);
        unique case (state)
            ST_READY: begin
                if (accept) begin
                    next_chipSelect_n = 1'b0;
                    next_sdramAddr    = muxAddr;
                    unique case (cmdCode)
                        SDMAC_ACT: begin
                            next_strobes   = PC_ACT;
                            next_apPin     = muxAp;
                            next_upperAddr = muxUpper;
                        end
                        SDMAC_READ: begin
                            next_strobes     = PC_RW_RD;
                            next_apPin       = 1'b0;
                            next_burstCycles = burstLen(burstLengthField);
                        end
                        SDMAC_WRITE: begin
                            next_strobes     = PC_RW_WR;
                            next_apPin       = 1'b0;
                            next_burstCycles = burstLen(burstLengthField);
                        end
                        SDMAC_BTERM: begin
                            next_strobes = PC_BTERM;
                        end
                        SDMAC_PRE: begin
                            next_strobes = PC_PRE;
                            next_apPin   = 1'b1;
                        end
                        SDMAC_REF: begin
                            next_strobes = PC_REF;
                        end
                        default: begin
                            next_strobes = PC_NOP;
                        end
                    endcase
                    if (timerStart) begin
                        next_state = ST_WAIT;
                    end
                end else if (loadNow) begin
                    next_chipSelect_n = 1'b0;
                    next_strobes      = PC_LOAD;
                    next_apPin        = 1'b0;
                    next_sdramAddr    = muxAddr;
                    next_loadModeDone = 1'b1;
                end
            end
            ST_WAIT: begin
                next_chipSelect_n = 1'b0;
                next_strobes      = PC_NOP;
                if (timerLast) begin
                    next_state = ST_READY;
                end
            end
            default: begin
                next_state = ST_READY;
            end
        endcase
        next_cmdReady = (next_state == ST_READY) && !next_loadPend && sdramMode;
    end

    // Read latency from the live timing field
    always_comb begin
        next_latCount = latCount;
        if (accept && cmdCode == SDMAC_READ) begin
            next_latCount = {1'b0, burstTimingField} + LAT_W'(1);
        end else if (latCount != '0) begin
            next_latCount = latCount - LAT_W'(1);
        end
        next_readDataStrobe = (latCount == LAT_W'(1));
    end

    // Option B gating
    always_comb begin
        next_effectiveOptionB = '0;
        if (externalTransferAckEnable) begin
            next_effectiveOptionB = optionBField;
        end
    end

    // Burst length decode
    function automatic logic [BLEN_W-1:0] burstLen(input logic [1:0] code);
        logic [BLEN_W-1:0] len;
        len = BL_PAGE;
        if (code == 2'h0) begin
            len = BL_2;
        end else if (code == 2'h1) begin
            len = BL_4;
        end else if (code == 2'h2) begin
            len = BL_8;
        end
        return len;
    endfunction

    // State and output registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state            <= ST_READY;
            validPrev        <= 1'b0;
            loadPend         <= 1'b0;
            cmdReady         <= 1'b0;
            loadModeDone     <= 1'b0;
            readDataStrobe   <= 1'b0;
            burstCycles      <= BL_PAGE;
            effectiveOptionB <= '0;
            chipSelect_n     <= 1'b1;
            strobes          <= PC_NOP;
            apPin            <= 1'b1;
            sdramAddr        <= '0;
            upperAddr        <= '0;
            latCount         <= '0;
        end else if (clkEn) begin
            state            <= next_state;
            validPrev        <= validBit;
            loadPend         <= next_loadPend;
            cmdReady         <= next_cmdReady;
            loadModeDone     <= next_loadModeDone;
            readDataStrobe   <= next_readDataStrobe;
            burstCycles      <= next_burstCycles;
            effectiveOptionB <= next_effectiveOptionB;
            chipSelect_n     <= next_chipSelect_n;
            strobes          <= next_strobes;
            apPin            <= next_apPin;
            sdramAddr        <= next_sdramAddr;
            upperAddr        <= next_upperAddr;
            latCount         <= next_latCount;
        end
    end

    // Strobe pin assignment
    assign columnStrobe3Pin_n = strobes[2];
    assign columnStrobe2Pin_n = strobes[1];
    assign columnStrobe1Pin_n = strobes[0];
    assign columnStrobe0Pin_n = apPin;

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n || !clkEn);

    read_code_a: assert property (accept && cmdCode == SDMAC_READ |=>
        !chipSelect_n && strobes == 3'h5 && !columnStrobe0Pin_n && sdramAddr[13:11] == 3'h0)
        else $error("read command encoding wrong");
    write_code_a: assert property (accept && cmdCode == SDMAC_WRITE |=>
        !chipSelect_n && strobes == 3'h4 && !columnStrobe0Pin_n
        && sdramAddr[7:0] == $past(muxAddr[7:0]))
        else $error("write command encoding wrong");
    precharge_code_a: assert property (accept && cmdCode == SDMAC_PRE |=>
        !chipSelect_n && strobes == 3'h2 && columnStrobe0Pin_n)
        else $error("precharge encoding wrong");
    active_row_a: assert property (accept && cmdCode == SDMAC_ACT && portWidthField == 2'h0 |=>
        strobes == 3'h3 && columnStrobe0Pin_n == $past(cmdAddr[20]) && sdramAddr[9:0] == $past(cmdAddr[19:10]))
        else $error("active row mapping wrong");
    load_code_a: assert property (loadModeDone |->
        !chipSelect_n && strobes == 3'h0 && !columnStrobe0Pin_n
        && sdramAddr[2:0] == 3'h7 && sdramAddr[9] && sdramAddr[6:4] == {1'b0, $past(burstTimingField)} + 3'h1)
        else $error("load-mode image wrong");
    wait_nop_a: assert property (accept && cmdCode == SDMAC_ACT && waitField == 4'h2 |=>
        ##1 (!chipSelect_n && strobes == 3'h7) [*2] ##0 state == ST_READY)
        else $error("wait states after active wrong");
    read_latency_a: assert property (accept && cmdCode == SDMAC_READ && burstTimingField == 2'h1
        |-> ##3 readDataStrobe)
        else $error("read latency wrong");
    optb_gate_a: assert property (!externalTransferAckEnable |=> effectiveOptionB == 8'h00)
        else $error("option B not gated");
    inhibit_idle_a: assert property (state == ST_READY && !accept && !loadNow |=>
        chipSelect_n)
        else $error("idle slot not inhibit");
endmodule
`default_nettype wire

// File: testbench/sdmac_sdram_model.sv
// Behavioural SDRAM device that decodes only the load-mode command and keeps its mode register
`timescale 1ns/1ns
`default_nettype none
module sdmac_sdram_model (
    // Clock
    input  wire logic        clk,
    // Command pins
    input  wire logic        chipSelect_n,
    input  wire logic        rowStrobe_n,
    input  wire logic        colStrobe_n,
    input  wire logic        writeEnable_n,
    input  wire logic        autoPrecharge,
    input  wire logic [13:0] addr,
    // Mode register view
    output logic      [13:0] modeReg,
    output logic      [2:0]  casLatency
);
    // Power-up contents of the mode register
    initial begin
        modeReg = 14'h0000;
        casLatency = 3'h0;
    end

    // Commands are taken on the rising edge while selected; load-mode is all pins low
    always @(posedge clk) begin
        if (!chipSelect_n && !rowStrobe_n && !colStrobe_n && !writeEnable_n && !autoPrecharge) begin
            modeReg <= addr;
            casLatency <= addr[6:4];
        end
    end
endmodule
`default_nettype wire

// File: testbench/tb_sdram_mode1_addr_cmd.sv
// Self-checking bench for the SDRAM command and address block
`timescale 1ns/1ns
`default_nettype none
module tb_sdram_mode1_addr_cmd
    import sdmac_pkg::*;
;
    typedef struct packed {
        logic [2:0]  code;
        logic        ap;
        logic [13:0] addr;
        logic [8:0]  bl;
        logic [5:0]  up;
    } sdmac_exp_t;

    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        clkEn = 1'b1;
    logic        sdramMode, validBit, extAck, cmdValid;
    logic [1:0]  pw, bTiming, blen;
    logic [3:0]  waitField;
    logic [7:0]  optB, effOptB;
    sdmac_cmd_t  cmdCode;
    logic [27:0] la;
    logic        cmdReady, loadDone, rdStrobe, csN, rasN, casN, weN, apPin;
    logic [8:0]  burstCycles;
    logic [13:0] sdramAddr, modeReg;
    logic [5:0]  upperAddr;
    logic [2:0]  casLat;
    logic [7:0]  rdHist;
    sdmac_exp_t  expQ[$];
    sdmac_exp_t  seenE;
    int          badCount = 0;
    int          checked = 0;
    int          cycles = 0;
    int          rnd;

    // Clock generator
    always #10 clk = ~clk;

    sdmac_cmd_ctrl u_dut (
        .clk(clk), .arst_n(arst_n), .clkEn(clkEn), .sdramMode(sdramMode), .validBit(validBit),
        .portWidthField(pw), .burstTimingField(bTiming), .burstLengthField(blen), .waitField(waitField),
        .externalTransferAckEnable(extAck), .optionBField(optB), .cmdValid(cmdValid), .cmdCode(cmdCode),
        .cmdAddr(la), .cmdReady(cmdReady), .loadModeDone(loadDone), .readDataStrobe(rdStrobe),
        .burstCycles(burstCycles), .effectiveOptionB(effOptB), .chipSelect_n(csN),
        .columnStrobe3Pin_n(rasN), .columnStrobe2Pin_n(casN), .columnStrobe1Pin_n(weN),
        .columnStrobe0Pin_n(apPin), .sdramAddr(sdramAddr), .upperAddr(upperAddr)
    );

    sdmac_sdram_model u_mem (
        .clk(clk), .chipSelect_n(csN), .rowStrobe_n(rasN), .colStrobe_n(casN), .writeEnable_n(weN),
        .autoPrecharge(apPin), .addr(sdramAddr), .modeReg(modeReg), .casLatency(casLat)
    );

    // Comparison with mismatch report
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            badCount++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic conclude();
        if (badCount == 0 && checked > 0 && expQ.size() == 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Expected pin image for a request
    function automatic sdmac_exp_t expect_cmd(input sdmac_cmd_t c, input logic [27:0] a);
        sdmac_exp_t e;
        logic [27:0] sh;
        sh = (pw == PW_8) ? a : (pw == PW_16) ? (a >> 1) : (a >> 2);
        e = '0;
        e.up = sh[27:22];
        e.bl = (blen == 2'h3) ? 9'h100 : (9'h002 << blen);
        case (c)
            SDMAC_ACT:   begin e.code = 3'h3; e.ap = sh[18]; e.addr = {sh[21:19], sh[18], sh[17:8]}; end
            SDMAC_READ:  begin e.code = 3'h5; e.addr = {6'h00, sh[7:0]}; end
            SDMAC_WRITE: begin e.code = 3'h4; e.addr = {6'h00, sh[7:0]}; end
            SDMAC_BTERM: e.code = 3'h6;
            SDMAC_PRE:   begin e.code = 3'h2; e.ap = 1'b1; end
            SDMAC_REF:   e.code = 3'h1;
            default:     e.code = 3'h7;
        endcase
        return e;
    endfunction

    // Drive one request at a falling edge and note what the pins must show
    task automatic issue(input sdmac_cmd_t c, input logic [27:0] a);
        int n;
        sdmac_exp_t nop;
        n = 0;
        nop = '0;
        nop.code = 3'h7;
        cmdValid = 1'b1;
        cmdCode = c;
        la = a;
        // Ready is registered, so its value at the falling edge is what the next rising edge sees
        while (cmdReady !== 1'b1 && n < 60) begin
            @(negedge clk);
            n++;
        end
        chk("request taken", cmdReady, 1'b1);
        @(posedge clk);
        expQ.push_back(expect_cmd(c, a));
        if (c == SDMAC_ACT || c == SDMAC_PRE) begin
            for (int i = 0; i < waitField; i++) expQ.push_back(nop);
        end
        @(negedge clk);
    endtask

    // Reset with port width already in place
    task automatic do_reset();
        arst_n = 1'b0;
        validBit = 1'b0;
        cmdValid = 1'b0;
        repeat (20) @(negedge clk);
        chk("select in reset", csN, 1'b1);
        chk("ready in reset", cmdReady, 1'b0);
        chk("burst in reset", burstCycles, 9'h100);
        arst_n = 1'b1;
        @(negedge clk);
    endtask

    // Setting the valid bit requests load-mode
    task automatic load_mode();
        sdmac_exp_t e;
        e = '0;
        e.addr = {4'h0, 1'b1, 2'h0, {1'b0, bTiming} + 3'h1, 1'b0, 3'h7};
        expQ.push_back(e);
        validBit = 1'b1;
        repeat (4) @(negedge clk);
        chk("mode latency", casLat, {1'b0, bTiming} + 3'h1);
        chk("mode image", modeReg, e.addr);
    endtask

    // Pin watcher: takes the oldest note whenever the memory is selected
    always @(negedge clk) begin
        if (!arst_n) begin
            rdHist = 8'h00;
        end else begin
            rdHist = {rdHist[6:0], (csN === 1'b0 && {rasN, casN, weN} === 3'h5)};
            chk("read strobe", rdStrobe, rdHist[{1'b0, bTiming} + 3'h1]);
            if (csN !== 1'b1) begin
                if (expQ.size() == 0) begin
                    chk("unexpected select", csN, 1'b1);
                end else begin
                    seenE = expQ.pop_front();
                    chk("strobes", {rasN, casN, weN}, seenE.code);
                    if (seenE.code inside {3'h0, 3'h2, 3'h3, 3'h4, 3'h5}) chk("a10 ap", apPin, seenE.ap);
                    if (seenE.code inside {3'h0, 3'h3, 3'h4, 3'h5}) chk("address", sdramAddr, seenE.addr);
                    if (seenE.code inside {3'h4, 3'h5}) chk("burst", burstCycles, seenE.bl);
                    if (seenE.code == 3'h3) chk("upper", upperAddr, seenE.up);
                    chk("load done", loadDone, seenE.code == 3'h0);
                end
            end
        end
    end

    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 8000) begin
            badCount++;
            conclude();
        end
    end

    // Main sequence
    initial begin
        rnd = $urandom(32'h68DDC5E4);
        {sdramMode, validBit, extAck, cmdValid} = 4'h8;
        {pw, bTiming, blen, waitField, optB, la} = '0;
        cmdCode = SDMAC_NOP;
        @(negedge clk);
        for (int p = 0; p < 3; p++) begin
            pw = (p == 0) ? PW_8 : (p == 1) ? PW_16 : PW_32;
            bTiming = (p == 1) ? 2'h1 : 2'($urandom_range(3, 0));
            blen = 2'h3;
            do_reset();
            load_mode();
            for (int k = 0; k < 4; k++) begin
                waitField = (k == 3) ? 4'hF : (k == 0) ? 4'h2 : 4'($urandom_range(2, 0));
                rnd = $urandom;
                issue(SDMAC_ACT, 28'(rnd));
                issue(SDMAC_READ, 28'(rnd));
                issue(SDMAC_WRITE, 28'($urandom));
                issue(SDMAC_BTERM, 28'($urandom));
                issue(SDMAC_NOP, 28'($urandom));
                issue(SDMAC_REF, 28'($urandom));
                issue(SDMAC_PRE, 28'($urandom));
                cmdValid = 1'b0;
                // Long enough for the longest wait-state tail to drain
                repeat (20) @(negedge clk);
                blen = 2'(k);
                bTiming = 2'($urandom_range(3, 0));
            end
        end
        // Clock enable low holds the registered outputs
        clkEn = 1'b0;
        extAck = 1'b1;
        optB = 8'hA5;
        repeat (2) @(negedge clk);
        chk("frozen option b", effOptB, 8'h00);
        clkEn = 1'b1;
        // Option B field follows the external acknowledge enable
        for (int e = 0; e < 2; e++) begin
            extAck = 1'(e);
            optB = 8'($urandom_range(255, 1));
            repeat (2) @(negedge clk);
            chk("option b", effOptB, extAck ? optB : 8'h00);
        end
        // A request outside SDRAM mode is held off
        sdramMode = 1'b0;
        @(negedge clk);
        cmdValid = 1'b1;
        cmdCode = SDMAC_READ;
        repeat (3) @(negedge clk);
        chk("ready off mode", cmdReady, 1'b0);
        chk("select off mode", csN, 1'b1);
        cmdValid = 1'b0;
        repeat (4) @(negedge clk);
        conclude();
    end
endmodule
`default_nettype wire
